// [bmx_asserts.sv]
// Checker on the channel's ports.
// Bound from the bench top; sees only bmx_channel ports.
module bmx_asserts
  import bmx_pkg::*;
(
  input wire logic                      clk,
  input wire logic                      srst,
  input wire logic                      reg_rd,
  input wire logic [31:0]               reg_rdata,
  input wire logic [bmx_pkg::NUM_CU-1:0] cu_poll,
  input wire logic                      cu_ack,
  input wire logic                      st_req,
  input wire logic                      st_we,
  input wire logic [bmx_pkg::ADDR_W-1:0] st_addr,
  input wire logic                      cpu_hold,
  input wire logic                      io_int
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Read data only right after a read
  property p_rd_zero; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("stray rdata");
  property p_poll_hot; cu_poll != 8'h00 |-> $onehot(cu_poll); endproperty
  a_poll_hot: assert property (p_poll_hot)
    else $error("poll not one-hot");
  // Poll steps one unit a cycle, wrapping
  property p_poll_walk; cu_poll != 8'h00 && $past(cu_poll) != 8'h00 |->
    cu_poll == (($past(cu_poll) << 1) | ($past(cu_poll) >> 7)); endproperty
  a_poll_walk: assert property (p_poll_walk)
    else $error("poll out of order");
  property p_serve; $fell(|cu_poll) |-> ##[1:8] (cu_ack || st_req);
  endproperty
  a_serve: assert property (p_serve)
    else $error("poll choice not served");
  property p_fetch; st_req && !st_we |=> cu_ack; endproperty
  a_fetch: assert property (p_fetch) else $error("fetch without ack");
  property p_hold_st; st_req |-> cpu_hold; endproperty
  a_hold_st: assert property (p_hold_st) else $error("cpu not held");
  property p_ack_one; cu_ack |=> !cu_ack; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_term; st_req && st_we && st_addr == STAT_LOC_CH |=>
    st_req && st_we && st_addr == STAT_LOC_DEV; endproperty
  a_term: assert property (p_term) else $error("status pair broken");
  property p_int; st_req && st_addr == STAT_LOC_DEV |-> ##[0:1] io_int;
  endproperty
  a_int: assert property (p_int) else $error("no interruption");
endmodule

// [bmx_channel.sv]
// Byte multiplexer / selector channel core.
// Assumes storage answers a read in the same cycle as st_req, and that
// control units hold their request until they see cu_ack.
//
// Notes on behaviour
// - Selector config: burst only, one transfer
// - Control-only starts never block a transfer
// - Hold instruction unit while channel busy
// - Channel storage access wins over processor
// - Termination: interrupt pulse, status in low storage
// - Eight control units, 256 device addresses
// - Byte-interleaved and burst operation both supported
// - Thirty-one subchannels
// - One operation per subchannel at once
// - Shared subchannel: one active device only
// - Interleaved mode moves one byte per service
// - Burst keeps channel until record done; here it frees the channel early if the unit drops its request
// - Each subchannel keeps count, address, key
// - Poll visits units in physical order
// - First ready high-priority unit is served
// - Load, move, update, write back, free
// - Read data stored only under program key
// - Store allowed on key match or zero
//
// Chosen here: the register addresses and the strobed register port.
module bmx_channel
  import bmx_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     srst,
  // Register port
  input  wire logic [bmx_pkg::RA_W-1:0] reg_addr,
  input  wire logic [31:0]              reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [31:0]              reg_rdata,
  // Control unit side
  input  wire logic [bmx_pkg::NUM_CU-1:0]   cu_req,
  input  wire logic [8*bmx_pkg::NUM_CU-1:0] cu_data_in,
  output logic      [bmx_pkg::NUM_CU-1:0]   cu_poll,
  output logic                              cu_ack,
  output logic      [7:0]                   cu_data_out,
  output logic      [bmx_pkg::DEV_W-1:0]    cu_dev,
  // Processor storage side
  output logic                          st_req,
  output logic                          st_we,
  output logic [bmx_pkg::ADDR_W-1:0]    st_addr,
  output logic [7:0]                    st_wdata,
  input  wire logic [7:0]               st_rdata,
  // Instruction unit side
  output logic                          cpu_hold,
  output logic                          io_int,
  output logic [bmx_pkg::SUB_W-1:0]     io_int_sub
);

  // ----------------------------------------------------------------
  // Software-visible state
  // ----------------------------------------------------------------
  logic [1:0]            ctrl_reg;       // Burst and selector bits
  logic [SUB_W-1:0]      subsel_reg;     // Subchannel for a start
  logic [CNT_W-1:0]      scount_reg;     // Count staged for start
  logic [ADDR_W-1:0]     saddr_reg;      // Address staged for start
  logic [NUM_SUB-1:0]    sub_busy_reg;   // Operation running
  logic                  xfer_busy_reg;  // Selector transfer owner
  logic                  refuse_reg;     // Last start refused
  logic                  prot_last_reg;  // Last end had key error
  logic [KEY_W-1:0]      blk_key [NUM_BLK]; // Block protection keys
  logic [SUB_W-1:0]      cu_sub [NUM_CU];   // CU to subchannel map
  logic [NUM_CU-1:0]     cu_hi_reg;      // High-priority marks

  // ----------------------------------------------------------------
  // Channel working registers
  // ----------------------------------------------------------------
  bmx_state_t            state_reg;
  bmx_state_t            state_next;
  logic [CU_W-1:0]       cu_idx_reg;     // Unit being served
  logic [SUB_W-1:0]      sub_reg;        // Its subchannel
  logic [CNT_W-1:0]      cnt_reg;        // Remaining bytes
  logic [ADDR_W-1:0]     addr_reg;       // Next storage address
  logic [KEY_W-1:0]      key_reg;        // Program key
  logic                  dir_reg;        // 1 = into storage
  logic [DEV_W-1:0]      dev_reg;        // Device on the unit
  logic                  err_reg;        // Key violation seen

  // ----------------------------------------------------------------
  // Decodes
  // ----------------------------------------------------------------
  // burst or byte-interleaved by mode
  wire burst_mode = ctrl_reg[CTRL_BURST_BIT] | ctrl_reg[CTRL_SEL_BIT];
  wire sel_cfg    = ctrl_reg[CTRL_SEL_BIT];
  wire wr_ctrl    = reg_wr & (reg_addr == REG_CTRL);
  wire wr_subsel  = reg_wr & (reg_addr == REG_SUBSEL);
  wire wr_count   = reg_wr & (reg_addr == REG_COUNT);
  wire wr_addr    = reg_wr & (reg_addr == REG_ADDR);
  wire wr_cmd     = reg_wr & (reg_addr == REG_CMD);
  wire wr_keytab  = reg_wr & (reg_addr == REG_KEYTAB);
  wire wr_cumap   = reg_wr & (reg_addr == REG_CUMAP);
  wire ctl_only   = (scount_reg == '0);
  wire sub_ok     = (subsel_reg < SUB_W'(NUM_SUB)) &&
                    !sub_busy_reg[subsel_reg];
  wire start_ok   = sub_ok && (ctl_only || !sel_cfg || !xfer_busy_reg);
  wire start_go   = wr_cmd & start_ok & !ctl_only;

  // Byte from the unit being served
  wire [7:0] cu_byte = cu_data_in[8*cu_idx_reg +: 8];

  // Protection block of the current address
  wire [BLK_W-1:0] blk = addr_reg[BLK_SHIFT +: BLK_W];
  // match or key zero may store
  wire key_ok = (key_reg == blk_key[blk]) || (key_reg == '0);
  wire cnt_done = (cnt_reg == '0);

  // ----------------------------------------------------------------
  // Poll chain and state word memory
  // ----------------------------------------------------------------
  logic            poll_found;
  logic            poll_done;
  logic [CU_W-1:0] poll_sel;
  logic [SW_W-1:0] sw_rdata;
  wire             poll_start = (state_reg == BMX_IDLE) && (|cu_req);

  bmx_poll #(.N(NUM_CU), .IW(CU_W)) u_poll (
    .clk   (clk),
    .srst  (srst),
    .start (poll_start),
    .req   (cu_req),
    .hipri (cu_hi_reg),
    .poll  (cu_poll),
    .found (poll_found),
    .done  (poll_done),
    .sel   (poll_sel)
  );

  // count, address, key kept per subchannel
  wire [SW_W-1:0] sw_wb = {dev_reg, dir_reg, key_reg, addr_reg, cnt_reg};
  wire [SW_W-1:0] sw_new = {reg_wdata[CMD_DEV_LSB +: DEV_W],
                            reg_wdata[CMD_DIR_BIT],
                            reg_wdata[KEY_W-1:0], saddr_reg, scount_reg};
  wire [SUB_W-1:0] sw_raddr = (state_reg == BMX_POLL) ?
                              cu_sub[poll_sel] : sub_reg;

  bmx_ssw_store #(.DEPTH(NUM_SUB), .AW(SUB_W), .W(SW_W)) u_ssw (
    .clk     (clk),
    .we_a    (state_reg == BMX_WBACK),
    .waddr_a (sub_reg),
    .wdata_a (sw_wb),
    .we_b    (start_go),
    .waddr_b (subsel_reg),
    .wdata_b (sw_new),
    .raddr   (sw_raddr),
    .rdata   (sw_rdata)
  );

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  // load, move, update, write back, free
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      BMX_IDLE:  if (poll_start) state_next = BMX_POLL;
      BMX_POLL:
        if (poll_found)
          state_next = BMX_LOAD;
        else if (poll_done)
          state_next = BMX_IDLE;
      BMX_LOAD:  state_next = BMX_MOVE;
      BMX_MOVE:  state_next = BMX_DATA;
      BMX_DATA:  state_next = BMX_WBACK;
      BMX_WBACK:
        if (cnt_done || err_reg)
          state_next = BMX_TERM0;
        else if (burst_mode && cu_req[cu_idx_reg])
          state_next = BMX_MOVE;
        // byte mode frees after one byte
        else
          state_next = BMX_IDLE;
      BMX_TERM0: state_next = BMX_TERM1;
      BMX_TERM1: state_next = BMX_IDLE;
    endcase
  end

  // Sequencer state
  always_ff @(posedge clk)
  begin
    if (srst)
      state_reg <= BMX_IDLE;
    else
      state_reg <= state_next;
  end

  // ----------------------------------------------------------------
  // Working registers
  // ----------------------------------------------------------------
  // Load on LOAD, step after each byte moved
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cu_idx_reg <= '0;
      sub_reg    <= '0;
      cnt_reg    <= '0;
      addr_reg   <= '0;
      key_reg    <= '0;
      dir_reg    <= 1'b0;
      dev_reg    <= '0;
      err_reg    <= 1'b0;
    end
    else if (state_reg == BMX_POLL && poll_found)
    begin
      cu_idx_reg <= poll_sel;
      sub_reg    <= cu_sub[poll_sel];
    end
    else if (state_reg == BMX_LOAD)
    begin
      cnt_reg  <= sw_rdata[SW_CNT_LSB +: CNT_W];
      addr_reg <= sw_rdata[SW_ADDR_LSB +: ADDR_W];
      key_reg  <= sw_rdata[SW_KEY_LSB +: KEY_W];
      dir_reg  <= sw_rdata[SW_DIR_BIT];
      dev_reg  <= sw_rdata[SW_DEV_LSB +: DEV_W];
      err_reg  <= 1'b0;
    end
    else if (state_reg == BMX_MOVE)
    begin
      if (dir_reg && !key_ok)
        err_reg <= 1'b1;
      else
      begin
        cnt_reg  <= cnt_reg - CNT_W'(1);
        addr_reg <= addr_reg + ADDR_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Storage, control unit and processor outputs
  // ----------------------------------------------------------------
  // All outputs registered; storage strobes last one cycle
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_req      <= 1'b0;
      st_we       <= 1'b0;
      st_addr     <= '0;
      st_wdata    <= '0;
      cu_ack      <= 1'b0;
      cu_data_out <= '0;
      cu_dev      <= '0;
      cpu_hold    <= 1'b0;
      io_int      <= 1'b0;
      io_int_sub  <= '0;
    end
    else
    begin
      st_req <= 1'b0;
      st_we  <= 1'b0;
      cu_ack <= 1'b0;
      io_int <= 1'b0;
      // channel storage use goes first
      // Held through the last status store as well
      cpu_hold <= ((state_next != BMX_IDLE) &&
                   (state_next != BMX_POLL)) ||
                  (state_reg == BMX_TERM1);
      if (state_reg == BMX_MOVE)
      begin
        st_req   <= !dir_reg || key_ok;
        st_we    <= dir_reg && key_ok;
        st_addr  <= addr_reg;
        st_wdata <= cu_byte;
        cu_dev   <= dev_reg;
      end
      if (state_reg == BMX_DATA)
      begin
        // Fetched byte handed over with service acknowledge
        cu_ack <= 1'b1;
        if (!dir_reg)
          cu_data_out <= st_rdata;
      end
      if (state_reg == BMX_TERM0)
      begin
        st_req   <= 1'b1;
        st_we    <= 1'b1;
        st_addr  <= STAT_LOC_CH;
        st_wdata <= {err_reg, 2'h0, sub_reg};
      end
      if (state_reg == BMX_TERM1)
      begin
        st_req     <= 1'b1;
        st_we      <= 1'b1;
        st_addr    <= STAT_LOC_DEV;
        st_wdata   <= dev_reg;
        io_int     <= 1'b1;
        io_int_sub <= sub_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register writes and busy tracking
  // ----------------------------------------------------------------
  wire term_now = (state_reg == BMX_TERM1);

  // Start bookkeeping; a start in the same cycle wins over the end-of-operation clear
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ctrl_reg      <= CTRL_RST;
      subsel_reg    <= '0;
      scount_reg    <= '0;
      saddr_reg     <= '0;
      sub_busy_reg  <= '0;
      xfer_busy_reg <= 1'b0;
      refuse_reg    <= 1'b0;
      prot_last_reg <= 1'b0;
      cu_hi_reg     <= '0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_reg <= reg_wdata[1:0];
      if (wr_subsel)
        subsel_reg <= reg_wdata[SUB_W-1:0];
      if (wr_count)
        scount_reg <= reg_wdata[CNT_W-1:0];
      if (wr_addr)
        saddr_reg <= reg_wdata[ADDR_W-1:0];
      if (wr_cmd)
        refuse_reg <= !start_ok;
      if (wr_cumap)
        cu_hi_reg[reg_wdata[IDX_LSB +: CU_W]] <= reg_wdata[CUMAP_HI_BIT];
      if (term_now)
      begin
        sub_busy_reg[sub_reg] <= 1'b0;
        xfer_busy_reg         <= 1'b0;
        prot_last_reg         <= err_reg;
      end
      // A start never names the ending subchannel, it is still busy
      if (start_go)
      begin
        sub_busy_reg[subsel_reg] <= 1'b1;
        xfer_busy_reg            <= 1'b1;
      end
    end
  end

  // Key table and unit map hold settings, no reset needed
  always_ff @(posedge clk)
  begin
    if (wr_keytab)
      blk_key[reg_wdata[IDX_LSB +: BLK_W]] <= reg_wdata[KEY_W-1:0];
    if (wr_cumap)
      cu_sub[reg_wdata[IDX_LSB +: CU_W]] <= reg_wdata[SUB_W-1:0];
  end

  // ----------------------------------------------------------------
  // Register reads, data one cycle after the strobe
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = '0;
    unique case (reg_addr)
      REG_CTRL:   rd_mux = {30'h0, ctrl_reg};
      REG_STATUS:
      begin
        rd_mux[ST_BUSY_BIT]   = (state_reg != BMX_IDLE);
        rd_mux[ST_XFER_BIT]   = xfer_busy_reg;
        rd_mux[ST_REFUSE_BIT] = refuse_reg;
        rd_mux[ST_PROT_BIT]   = prot_last_reg;
        rd_mux[ST_SUB_LSB +: SUB_W] = sub_reg;
      end
      REG_SUBSEL: rd_mux[SUB_W-1:0]  = subsel_reg;
      REG_COUNT:  rd_mux[CNT_W-1:0]  = scount_reg;
      REG_ADDR:   rd_mux[ADDR_W-1:0] = saddr_reg;
      REG_BUSY:   rd_mux[NUM_SUB-1:0] = sub_busy_reg;
      default:    rd_mux = '0;
    endcase
  end

  // Read data register
  always_ff @(posedge clk)
  begin
    if (srst)
      reg_rdata <= '0;
    else if (reg_rd)
      reg_rdata <= rd_mux;
    else
      reg_rdata <= '0;
  end

endmodule

// [bmx_cu_model.sv]
// Behavioural control units on the channel.
// Assumes a one-hot poll and one ack per served byte.
module bmx_cu_model
(
  input wire logic        clk,
  input wire logic        srst,
  input wire logic [7:0]  want,
  input wire logic [7:0]  base,
  input wire logic [7:0]  cu_poll,
  input wire logic        cu_ack,
  output logic     [7:0]  cu_req,
  output logic     [63:0] cu_data_in
);
  logic [7:0] served; // Unit the poll last stood on
  always_ff @(posedge clk)
  begin
    if (cu_poll != 8'h00)
      served <= cu_poll;
    cu_req <= srst ? 8'h00 : (cu_req | want) & ~(cu_ack ? served : 8'h00);
  end
  // Idle units show inverted bytes, never a stale match
  always_comb
    for (int i = 0; i < 8; i++)
      cu_data_in[8*i +: 8] = cu_req[i] ? base + 8'(i) : ~(base + 8'(i));
endmodule

// [bmx_pkg.sv]
// Shared constants and types for the byte multiplexer channel.
// Assumes one 10 MHz clock and a synchronous active-high reset.
package bmx_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_CU    = 8;     // Control units on the channel
  localparam int CU_W      = 3;     // Control unit index width
  localparam int NUM_SUB   = 31;    // Subchannels
  localparam int SUB_W     = 5;     // Subchannel index width
  localparam int DEV_W     = 8;     // 256 device addresses
  localparam int ADDR_W    = 16;    // Storage byte address width
  localparam int CNT_W     = 16;    // Byte count width
  localparam int KEY_W     = 4;     // Protection key width
  localparam int BLK_SHIFT = 11;    // 2048-byte protection blocks
  localparam int NUM_BLK   = 32;    // Blocks in the address space
  localparam int BLK_W     = 5;     // Block index width
  localparam int RA_W      = 8;     // Register address width

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [RA_W-1:0] REG_CTRL   = 8'h00; // Mode control
  localparam logic [RA_W-1:0] REG_STATUS = 8'h04; // Channel state
  localparam logic [RA_W-1:0] REG_SUBSEL = 8'h08; // Subchannel select
  localparam logic [RA_W-1:0] REG_COUNT  = 8'h0C; // Start byte count
  localparam logic [RA_W-1:0] REG_ADDR   = 8'h10; // Start address
  localparam logic [RA_W-1:0] REG_CMD    = 8'h14; // Start command
  localparam logic [RA_W-1:0] REG_KEYTAB = 8'h18; // Block key write
  localparam logic [RA_W-1:0] REG_CUMAP  = 8'h1C; // CU to subchannel
  localparam logic [RA_W-1:0] REG_BUSY   = 8'h20; // Busy subchannels

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_BURST_BIT = 0;  // Byte mux runs burst mode
  localparam int CTRL_SEL_BIT   = 1;  // Selector channel config
  localparam int CMD_DIR_BIT    = 4;  // 1 = read into storage
  localparam int CMD_DEV_LSB    = 8;  // Device address field
  localparam int IDX_LSB        = 8;  // Table index in KEYTAB/CUMAP
  localparam int CUMAP_HI_BIT   = 5;  // High-priority designation
  localparam int ST_BUSY_BIT    = 0;  // Channel serving
  localparam int ST_XFER_BIT    = 1;  // Selector transfer running
  localparam int ST_REFUSE_BIT  = 2;  // Last start refused
  localparam int ST_PROT_BIT    = 3;  // Last end had key error
  localparam int ST_SUB_LSB     = 8;  // Last served subchannel
  localparam logic [1:0] CTRL_RST = 2'h0;

  // Fixed low storage for termination status
  localparam logic [ADDR_W-1:0] STAT_LOC_CH  = 16'h0040;
  localparam logic [ADDR_W-1:0] STAT_LOC_DEV = 16'h0041;

  // ----------------------------------------------------------------
  // Subchannel state word layout
  // ----------------------------------------------------------------
  localparam int SW_CNT_LSB  = 0;
  localparam int SW_ADDR_LSB = SW_CNT_LSB + CNT_W;
  localparam int SW_KEY_LSB  = SW_ADDR_LSB + ADDR_W;
  localparam int SW_DIR_BIT  = SW_KEY_LSB + KEY_W;
  localparam int SW_DEV_LSB  = SW_DIR_BIT + 1;
  localparam int SW_W        = SW_DEV_LSB + DEV_W;

  // Channel sequencer states
  typedef enum logic [2:0] {
    BMX_IDLE, BMX_POLL, BMX_LOAD, BMX_MOVE,
    BMX_DATA, BMX_WBACK, BMX_TERM0, BMX_TERM1
  } bmx_state_t;

endpackage

// [bmx_poll.sv]
// Poll chain: visits control units in physical order, one a cycle.
// Assumes requests and priority marks are synchronous to clk.
module bmx_poll
  import bmx_pkg::*;
#(
  parameter int N   = bmx_pkg::NUM_CU,
  parameter int IW  = bmx_pkg::CU_W
)(
  input  wire logic          clk,
  input  wire logic          srst,
  input  wire logic          start,
  input  wire logic [N-1:0]  req,
  input  wire logic [N-1:0]  hipri,
  output logic      [N-1:0]  poll,
  output logic               found,
  output logic               done,
  output logic      [IW-1:0] sel
);

  // ----------------------------------------------------------------
  // Scan state
  // ----------------------------------------------------------------
  logic          run_reg;   // Poll signal travelling
  logic          pass_reg;  // 0 = high-priority pass, 1 = low pass
  logic [IW-1:0] idx_reg;   // Unit being inspected
  wire           last = (idx_reg == IW'(N - 1));
  // A unit answers on the high pass only if designated high
  wire           hit  = req[idx_reg] & (pass_reg | hipri[idx_reg]);

  // Walk the chain, stop at the first unit that answers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      run_reg  <= 1'b0;
      pass_reg <= 1'b0;
      idx_reg  <= '0;
      poll     <= '0;
      found    <= 1'b0;
      done     <= 1'b0;
      sel      <= '0;
    end
    else
    begin
      found <= 1'b0;
      done  <= 1'b0;
      if (!run_reg)
      begin
        // Idle until the channel frees itself
        poll <= '0;
        if (start)
        begin
          run_reg  <= 1'b1;
          pass_reg <= 1'b0;
          idx_reg  <= '0;
        end
      end
      else
      begin
        poll <= N'(1) << idx_reg;
        if (hit)
        begin
          run_reg <= 1'b0;
          found   <= 1'b1;
          done    <= 1'b1;
          sel     <= idx_reg;
        end
        else if (last)
        begin
          idx_reg  <= '0;
          pass_reg <= 1'b1;
          // Nobody answered either pass
          if (pass_reg)
          begin
            run_reg <= 1'b0;
            done    <= 1'b1;
          end
        end
        else
          idx_reg <= idx_reg + IW'(1);
      end
    end
  end

endmodule

// [bmx_ssw_store.sv]
// Per-subchannel state word memory, two write ports, one read port.
// Assumes the two write ports never name the same word in one cycle.
module bmx_ssw_store
  import bmx_pkg::*;
#(
  parameter int DEPTH = bmx_pkg::NUM_SUB,
  parameter int AW    = bmx_pkg::SUB_W,
  parameter int W     = bmx_pkg::SW_W
)(
  input  wire logic          clk,
  input  wire logic          we_a,
  input  wire logic [AW-1:0] waddr_a,
  input  wire logic [W-1:0]  wdata_a,
  input  wire logic          we_b,
  input  wire logic [AW-1:0] waddr_b,
  input  wire logic [W-1:0]  wdata_b,
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata
);

  // ----------------------------------------------------------------
  // Storage array
  // ----------------------------------------------------------------
  logic [W-1:0] mem [DEPTH];  // One state word per subchannel

  // Sequencer writes on port a, software starts on port b
  always_ff @(posedge clk)
  begin
    if (we_a)
      mem[waddr_a] <= wdata_a;
    if (we_b)
      mem[waddr_b] <= wdata_b;
    rdata <= mem[raddr];
  end

endmodule

// [tb.sv]
// Bench top: channel, control units, storage model.
// Assumes the register map and contract of the channel.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import bmx_pkg::*;
  `define CHK(n, e, a) begin logic [31:0] x_; x_ = e; compares++; \
    if ((a) !== x_) begin err_count++; \
    $display("[ERR] %s exp %h got %h", n, x_, a); end end
  logic clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, rd_d = 0;
  logic cu_ack, st_req, st_we, cpu_hold, io_int;
  logic [7:0] reg_addr = 0, want = 0, base = 0, cu_poll, cu_req, cu_dev;
  logic [7:0] cu_data_out, st_wdata, st_rdata, mem [0:65535];
  logic [31:0] reg_wdata = 0, reg_rdata, rq[$];
  logic [63:0] cu_data_in;
  logic [15:0] st_addr;
  logic [4:0] io_int_sub, iq[$];
  logic [7:0] dq[$];
  int err_count = 0, compares = 0;
  int kt[5] = '{0, 5, 9, 6, 0}; // Block keys
  initial forever #50 clk = ~clk;
  bmx_channel u_bmx_channel (.clk(clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cu_req(cu_req), .cu_data_in(cu_data_in),
    .cu_poll(cu_poll), .cu_ack(cu_ack), .cu_data_out(cu_data_out),
    .cu_dev(cu_dev), .st_req(st_req), .st_we(st_we), .st_addr(st_addr),
    .st_wdata(st_wdata), .st_rdata(st_rdata), .cpu_hold(cpu_hold),
    .io_int(io_int), .io_int_sub(io_int_sub));
  bmx_cu_model u_bmx_cu_model (.clk(clk), .srst(srst), .want(want),
    .base(base), .cu_poll(cu_poll), .cu_ack(cu_ack), .cu_req(cu_req),
    .cu_data_in(cu_data_in));
  // Storage answers in the cycle of st_req; idle bus shows inverse
  assign st_rdata = st_req ? mem[st_addr] : ~mem[st_addr];
  // Storage and result watcher
  always @(posedge clk)
  begin
    if (st_req && st_we)
      mem[st_addr] <= st_wdata;
    if (rd_d) `CHK("reg_rdata", rq.pop_front(), reg_rdata)
    if (cu_ack && dq.size() > 0) `CHK("cu_data_out", dq.pop_front(), cu_data_out)
    if (io_int) `CHK("cu_dev", 8'h20 + io_int_sub, cu_dev)
    if (io_int) `CHK("io_int_sub", iq.pop_front(), io_int_sub)
    rd_d <= reg_rd;
  end
  task automatic wr(input logic [7:0] a, input int d);
    reg_addr <= a;
    reg_wdata <= 32'(d);
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask
  // Device address is 0x20 plus subchannel
  task automatic start(input int s, c, ad, k, dir);
    wr(REG_SUBSEL, s);
    wr(REG_COUNT, c);
    wr(REG_ADDR, ad);
    wr(REG_CMD, k + 16 * dir + 256 * (32 + s));
  endtask
  task automatic kick(input logic [7:0] m);
    want <= m;
    @(posedge clk);
    want <= 8'h00;
    @(posedge clk);
  endtask
  // Bounded wait for every noted result
  task automatic wait_done();
    int n;
    n = 0;
    while (iq.size() + dq.size() + rq.size() > 0 && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    if (n == 400)
    begin
      err_count++;
      print_verdict();
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    void'($urandom(31));
    base <= 8'($urandom);
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(REG_CTRL, 0);
    rd(REG_BUSY, 0);
    wr(8'h3C, -1);
    rd(8'h3C, 0);
    foreach (kt[i]) wr(REG_KEYTAB, 256 * i + kt[i]);
    // Unit i on subchannel i+1, unit 2 high priority
    for (int i = 0; i < 4; i++) wr(REG_CUMAP, 257 * i + (i == 2 ? 33 : 1));
    mem[16'h1800] = 8'h5A;
    start(1, 1, 16'h0800, 5, 1);
    start(2, 1, 16'h1800, 7, 1);
    start(3, 1, 16'h1000, 0, 1);
    iq = '{5'h03, 5'h01, 5'h02};
    kick(8'h07);
    wait_done();
    `CHK("mem0800", base, mem[16'h0800])
    `CHK("mem1000", 8'(base + 8'h02), mem[16'h1000])
    `CHK("mem1800", 8'h5A, mem[16'h1800])
    `CHK("chan_stat", 8'h82, mem[STAT_LOC_CH])
    `CHK("dev_stat", 8'h22, mem[STAT_LOC_DEV])
    mem[16'h2000] = 8'($urandom);
    mem[16'h2001] = 8'($urandom);
    start(4, 2, 16'h2000, 0, 0);
    dq.push_back(mem[16'h2000]);
    kick(8'h08);
    wait_done();
    dq.push_back(mem[16'h2001]);
    iq.push_back(5'h04);
    kick(8'h08);
    wait_done();
    start(5, 1, 16'h2800, 0, 1);
    start(5, 1, 16'h2800, 0, 1);
    rd(REG_STATUS, 32'h0406);
    start(31, 1, 16'h2800, 0, 1);
    rd(REG_STATUS, 32'h0406);
    wr(REG_CTRL, 2);
    start(6, 1, 16'h3000, 0, 1);
    start(7, 1, 16'h3000, 0, 1);
    rd(REG_STATUS, 32'h0406);
    start(8, 0, 16'h3000, 0, 1);
    rd(REG_STATUS, 32'h0402);
    rd(REG_BUSY, 32'h20);
    wait_done();
    print_verdict();
  end
endmodule
bind bmx_channel bmx_asserts u_bmx_asserts (.clk(clk), .srst(srst),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cu_poll(cu_poll),
  .cu_ack(cu_ack), .st_req(st_req), .st_we(st_we), .st_addr(st_addr),
  .cpu_hold(cpu_hold), .io_int(io_int));
